// *** irq_pkg.sv ***
/*
 Package for the interrupt priority and status save block: widths, field
 layouts, stack sequencer states and timing constants.
 Assumes the CPU core supplies its status word and pointers each cycle.
*/
package irq_pkg;
    localparam int NSRC = 16;
    localparam int SRC_W = 4;
    localparam int LVL_W = 4;
    localparam int RANK_W = 2;
    localparam int WORD_W = 16;
    localparam int SEG_W = 8;
    localparam int VEC_W = 16;
    localparam logic [LVL_W-1:0] LVL_NONE = 4'h0;
    localparam logic [LVL_W-1:0] LVL_TRANSFER = 4'hf;
    localparam int XFER_CHANNELS = 8;
    localparam logic [2:0] LOCK_MAX = 3'h4;
    localparam logic [2:0] LOCK_MIN = 3'h1;
    localparam logic [1:0] RESP_CYCLES = 2'h3;
    localparam int PSW_LVL_LSB = 12;
    localparam int PSW_MULDIV_BIT = 9;
    localparam int PSW_IRQ_ON_BIT = 11;
    localparam logic [WORD_W-1:0] PSW_RESET = 16'h0000;

    typedef struct packed {
        logic [LVL_W-1:0] priority_level_field;
        logic [RANK_W-1:0] group_rank_field;
    } src_prio_t;

    typedef struct packed {
        logic [WORD_W-1:0] processor_status_word;
        logic [WORD_W-1:0] return_offset_pointer;
        logic [SEG_W-1:0] code_segment_register;
    } cpu_state_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_PUSH_PSW = 3'b010,
        ST_PUSH_CSEG = 3'b011,
        ST_PUSH_RET = 3'b100,
        ST_POP_RET = 3'b101,
        ST_POP_CSEG = 3'b110,
        ST_POP_PSW = 3'b111
    } seq_t;
endpackage : irq_pkg

// *** irq_arbiter.sv ***
/*
 Priority arbiter: picks one winning source among enabled pending requests.
 Assumes request, enable and priority inputs are on the same clock.
*/
`timescale 1ns/1ps
module irq_arbiter (
    // Requests
    input wire logic [irq_pkg::NSRC-1:0] pending_i,
    input wire logic [irq_pkg::NSRC-1:0] source_enable_bit_i,
    input wire logic global_irq_on_i,
    input wire irq_pkg::src_prio_t [irq_pkg::NSRC-1:0] prio_i,
    // Winner
    output logic win_valid_o,
    output logic [irq_pkg::SRC_W-1:0] win_src_o,
    output irq_pkg::src_prio_t win_prio_o
);
    logic [irq_pkg::NSRC-1:0] eligible;

    genvar g;
    generate
        for (g = 0; g < irq_pkg::NSRC; g++) begin : g_elig
            assign eligible[g] = pending_i[g] && source_enable_bit_i[g]
                && global_irq_on_i
                && (prio_i[g].priority_level_field
                != irq_pkg::LVL_NONE);
        end
    endgenerate

    always_comb begin
        win_valid_o = 1'b0;
        win_src_o = '0;
        win_prio_o = '0;
        for (int i = 0; i < irq_pkg::NSRC; i++) begin
            // Level and rank together form one key; ties on the key go to
            // the lower source index so a single winner always results.
            if (eligible[i] && (!win_valid_o || prio_i[i] > win_prio_o)) begin
                win_valid_o = 1'b1;
                win_src_o = i[irq_pkg::SRC_W-1:0];
                win_prio_o = prio_i[i];
            end
        end
    end
endmodule : irq_arbiter

// *** irq_priority_save.sv ***
/*
 Interrupt arbitration and entry sequencer: accepts the winning request,
 pushes the saved state, clears the source flag and loads the vector, and
 unstacks on interrupt return.
 Assumes the core pulses its strobes for one cycle and holds them legal.
*/
`timescale 1ns/1ps
module irq_priority_save (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sources
    input wire logic [irq_pkg::NSRC-1:0] flag_set_i,
    input wire logic [irq_pkg::NSRC-1:0] source_enable_bit_i,
    input wire irq_pkg::src_prio_t [irq_pkg::NSRC-1:0] prio_i,
    input wire logic [irq_pkg::VEC_W-1:0] vector_base_i,
    // CPU core
    input wire irq_pkg::cpu_state_t cpu_i,
    input wire logic [irq_pkg::WORD_W-1:0] muldiv_addr_i,
    input wire logic muldiv_busy_i,
    input wire logic instr_done_i,
    input wire logic locked_sequence_op_i,
    input wire logic [1:0] lock_len_i,
    input wire logic interrupt_return_op_i,
    input wire logic [irq_pkg::WORD_W-1:0] pop_data_i,
    // System config
    input wire logic segmentation_off_bit_i,
    // Outputs
    output logic [irq_pkg::NSRC-1:0] pending_o,
    output logic push_o,
    output logic pop_o,
    output logic [irq_pkg::WORD_W-1:0] push_data_o,
    output logic load_o,
    output irq_pkg::cpu_state_t cpu_o,
    output logic vector_fetch_o,
    output logic busy_o
);
    irq_pkg::seq_t state;
    logic [irq_pkg::NSRC-1:0] pending;
    logic [2:0] lock_cnt;
    logic [1:0] resp_cnt;
    logic [irq_pkg::SRC_W-1:0] sel_src;
    irq_pkg::src_prio_t sel_prio;
    irq_pkg::cpu_state_t saved;
    logic win_valid;
    logic [irq_pkg::SRC_W-1:0] win_src;
    irq_pkg::src_prio_t win_prio;
    logic [irq_pkg::LVL_W-1:0] cpu_lvl;
    logic accept;
    logic [irq_pkg::NSRC-1:0] clr_mask;

    irq_arbiter u_arb (
        .pending_i(pending),
        .source_enable_bit_i(source_enable_bit_i),
        .global_irq_on_i(cpu_i.processor_status_word[irq_pkg::PSW_IRQ_ON_BIT]),
        .prio_i(prio_i),
        .win_valid_o(win_valid),
        .win_src_o(win_src),
        .win_prio_o(win_prio)
    );

    assign cpu_lvl = cpu_i.processor_status_word[irq_pkg::PSW_LVL_LSB +:
        irq_pkg::LVL_W];
    // Level fifteen sources are the event transfer channels; they take the
    // same path here and preempt anything below by plain level compare.
    assign accept = win_valid && (state == irq_pkg::ST_IDLE)
        && (win_prio.priority_level_field > cpu_lvl)
        && (lock_cnt == 3'h0);

    always_comb begin
        clr_mask = '0;
        if (state == irq_pkg::ST_PUSH_PSW) begin
            clr_mask[sel_src] = 1'b1;
        end
    end

    // A new flag in the clearing cycle wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~clr_mask) | flag_set_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_cnt <= 3'h0;
        end else if (locked_sequence_op_i) begin
            lock_cnt <= {1'b0, lock_len_i} + irq_pkg::LOCK_MIN;
        end else if (instr_done_i && lock_cnt != 3'h0) begin
            lock_cnt <= lock_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= irq_pkg::ST_IDLE;
            resp_cnt <= 2'h0;
            sel_src <= '0;
            sel_prio <= '0;
            saved <= '0;
        end else begin
            case (state)
                irq_pkg::ST_IDLE: begin
                    if (interrupt_return_op_i) begin
                        state <= irq_pkg::ST_POP_RET;
                    end else if (accept) begin
                        sel_src <= win_src;
                        sel_prio <= win_prio;
                        saved <= cpu_i;
                        if (muldiv_busy_i) begin
                            saved.processor_status_word[
                                irq_pkg::PSW_MULDIV_BIT] <= 1'b1;
                            saved.return_offset_pointer <= muldiv_addr_i;
                        end
                        resp_cnt <= 2'h1;
                        state <= irq_pkg::ST_WAIT;
                    end
                end
                irq_pkg::ST_WAIT: begin
                    if (instr_done_i) begin
                        resp_cnt <= resp_cnt + 2'h1;
                        if (resp_cnt == irq_pkg::RESP_CYCLES - 2'h1) begin
                            state <= irq_pkg::ST_PUSH_PSW;
                        end
                    end
                end
                irq_pkg::ST_PUSH_PSW: begin
                    state <= segmentation_off_bit_i ? irq_pkg::ST_PUSH_RET
                        : irq_pkg::ST_PUSH_CSEG;
                end
                irq_pkg::ST_PUSH_CSEG: state <= irq_pkg::ST_PUSH_RET;
                irq_pkg::ST_PUSH_RET: state <= irq_pkg::ST_IDLE;
                irq_pkg::ST_POP_RET: begin
                    saved.return_offset_pointer <= pop_data_i;
                    state <= segmentation_off_bit_i ? irq_pkg::ST_POP_PSW
                        : irq_pkg::ST_POP_CSEG;
                end
                irq_pkg::ST_POP_CSEG: begin
                    saved.code_segment_register <=
                        pop_data_i[irq_pkg::SEG_W-1:0];
                    state <= irq_pkg::ST_POP_PSW;
                end
                irq_pkg::ST_POP_PSW: begin
                    saved.processor_status_word <= pop_data_i;
                    state <= irq_pkg::ST_IDLE;
                end
                default: state <= irq_pkg::ST_IDLE;
            endcase
        end
    end

    // Only status, segment and offset are driven; data page and bank
    // pointers have no path through this block and so stay untouched.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            push_o <= 1'b0;
            pop_o <= 1'b0;
            push_data_o <= '0;
            load_o <= 1'b0;
            cpu_o <= '0;
            vector_fetch_o <= 1'b0;
            busy_o <= 1'b0;
            pending_o <= '0;
        end else begin
            pending_o <= pending;
            push_o <= 1'b0;
            pop_o <= 1'b0;
            load_o <= 1'b0;
            vector_fetch_o <= 1'b0;
            busy_o <= (state != irq_pkg::ST_IDLE);
            case (state)
                irq_pkg::ST_PUSH_PSW: begin
                    push_o <= 1'b1;
                    push_data_o <= saved.processor_status_word;
                end
                irq_pkg::ST_PUSH_CSEG: begin
                    push_o <= 1'b1;
                    push_data_o <= {{(irq_pkg::WORD_W-irq_pkg::SEG_W){1'b0}},
                        saved.code_segment_register};
                end
                irq_pkg::ST_PUSH_RET: begin
                    push_o <= 1'b1;
                    push_data_o <= saved.return_offset_pointer;
                    load_o <= 1'b1;
                    vector_fetch_o <= 1'b1;
                    cpu_o.processor_status_word <= saved.processor_status_word;
                    cpu_o.processor_status_word[irq_pkg::PSW_LVL_LSB +:
                        irq_pkg::LVL_W] <=
                        sel_prio.priority_level_field;
                    cpu_o.return_offset_pointer <= vector_base_i
                        + {{(irq_pkg::VEC_W-irq_pkg::SRC_W-2){1'b0}},
                        sel_src, 2'b00};
                    cpu_o.code_segment_register <= segmentation_off_bit_i
                        ? saved.code_segment_register : '0;
                end
                irq_pkg::ST_POP_RET, irq_pkg::ST_POP_CSEG,
                irq_pkg::ST_POP_PSW: begin
                    pop_o <= 1'b1;
                end
                default: begin
                end
            endcase
            if (state == irq_pkg::ST_POP_PSW) begin
                load_o <= 1'b1;
                cpu_o.processor_status_word <= pop_data_i;
                cpu_o.return_offset_pointer <= saved.return_offset_pointer;
                cpu_o.code_segment_register <= segmentation_off_bit_i
                    ? cpu_i.code_segment_register
                    : saved.code_segment_register;
            end
        end
    end
endmodule : irq_priority_save

// *** irq_priority_save_chk.sv ***
/*
 Port checker for the interrupt entry block.
 Assumes it is bound to irq_priority_save on its one clock.
*/
`timescale 1ns/1ps
module irq_priority_save_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Inputs watched
    input wire irq_pkg::cpu_state_t cpu_i,
    input wire logic interrupt_return_op_i,
    input wire logic segmentation_off_bit_i,
    // Outputs watched
    input wire logic push_o,
    input wire logic pop_o,
    input wire logic load_o,
    input wire irq_pkg::cpu_state_t cpu_o,
    input wire logic vector_fetch_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_first;
        push_o && !$past(push_o);
    endsequence
    sequence s_seg;
        push_o && !vector_fetch_o ##1 push_o && vector_fetch_o;
    endsequence
    a_push_seg: assert property (s_first ##0 !segmentation_off_bit_i
        |=> s_seg) else $error("segmented stacking order wrong");
    a_push_flat: assert property (s_first ##0 segmentation_off_bit_i
        |=> push_o && vector_fetch_o) else $error("flat stacking wrong");
    a_fetch_load: assert property (vector_fetch_o
        |-> load_o && push_o) else $error("fetch without load");
    a_level_zero: assert property (vector_fetch_o
        |-> cpu_o.processor_status_word[15:12] != irq_pkg::LVL_NONE)
        else $error("level zero serviced");
    a_cseg_clear: assert property (vector_fetch_o
        && !segmentation_off_bit_i
        |-> cpu_o.code_segment_register == 8'h00)
        else $error("code segment not cleared");
    a_gate_off: assert property ((!busy_o &&
        !cpu_i.processor_status_word[irq_pkg::PSW_IRQ_ON_BIT]) [*2]
        |=> !busy_o) else $error("accepted while globally off");
    a_pop_quiet: assert property (pop_o
        |-> !push_o && !vector_fetch_o) else $error("pop during entry");
    a_ret_load: assert property (interrupt_return_op_i && !busy_o
        |-> ##[2:6] load_o) else $error("return never restored");
    a_load_pulse: assert property (load_o |=> !load_o)
        else $error("load held too long");
endmodule : irq_priority_save_chk
bind irq_priority_save irq_priority_save_chk irq_priority_save_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cpu_i(cpu_i),
    .interrupt_return_op_i(interrupt_return_op_i),
    .segmentation_off_bit_i(segmentation_off_bit_i), .push_o(push_o),
    .pop_o(pop_o), .load_o(load_o), .cpu_o(cpu_o),
    .vector_fetch_o(vector_fetch_o), .busy_o(busy_o));

// *** cpu_core_model.sv ***
/*
 Core model: retires an instruction every other cycle and feeds stack words.
 Assumes the return strobe lasts one clock and the block is idle then.
*/
`timescale 1ns/1ps
module cpu_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controls
    input wire logic ret_i,
    input wire logic seg_off_i,
    input wire logic [47:0] words_i,
    // To the block
    output logic instr_done_o,
    output logic [15:0] pop_data_o
);
    logic [1:0] idx;
    always_ff @(posedge clk_i) begin
        instr_done_o <= !rst_i && !instr_done_o;
    end
    // Outside a return the word toggles so a stale sample cannot pass.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx <= 2'h0;
            pop_data_o <= 16'h0000;
        end else if (ret_i) begin
            idx <= 2'h1;
            pop_data_o <= words_i[15:0];
        end else if (idx == 2'h1) begin
            idx <= seg_off_i ? 2'h3 : 2'h2;
            pop_data_o <= seg_off_i ? words_i[47:32] : words_i[31:16];
        end else if (idx == 2'h2) begin
            idx <= 2'h3;
            pop_data_o <= words_i[47:32];
        end else begin
            idx <= 2'h0;
            pop_data_o <= ~pop_data_o;
        end
    end
endmodule : cpu_core_model

// *** irq_priority_save_tb_top.sv ***
/*
 Bench: entry, return, gating and lock scenarios.
 Assumes the core model drives retire and stack words.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module irq_priority_save_tb_top;
    int check_count = 0;
    int miscompares = 0;
    int pops = 0;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] flag_set_i = 16'h0000;
    logic [15:0] en = 16'h003c;
    irq_pkg::src_prio_t [15:0] prio = '0;
    irq_pkg::cpu_state_t cpu = {16'h2800, 16'h1234, 8'h05};
    logic mdb = 1'b0;
    logic lock = 1'b0;
    logic ret = 1'b0;
    logic seg_off = 1'b0;
    logic done, push, pop, load, fetch, busy;
    logic [15:0] pop_data, pend, pdata;
    irq_pkg::cpu_state_t cpu_out;
    logic [15:0] pushes[$];
    always #10 clk_i = ~clk_i;
    irq_priority_save irq_priority_save_inst (.clk_i(clk_i), .rst_i(rst_i),
        .flag_set_i(flag_set_i), .source_enable_bit_i(en), .prio_i(prio),
        .vector_base_i(16'h0100), .cpu_i(cpu), .muldiv_addr_i(16'h0abc),
        .muldiv_busy_i(mdb), .instr_done_i(done),
        .locked_sequence_op_i(lock), .lock_len_i(2'h3),
        .interrupt_return_op_i(ret), .pop_data_i(pop_data),
        .segmentation_off_bit_i(seg_off), .pending_o(pend), .push_o(push),
        .pop_o(pop), .push_data_o(pdata), .load_o(load), .cpu_o(cpu_out),
        .vector_fetch_o(fetch), .busy_o(busy));
    cpu_core_model cpu_core_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ret_i(ret), .seg_off_i(seg_off),
        .words_i({16'h3800, 16'h0007, 16'h2222}), .instr_done_o(done),
        .pop_data_o(pop_data));
    always @(posedge clk_i) begin
        if (push === 1'b1) pushes.push_back(pdata);
        if (pop === 1'b1) pops++;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic wait_on(input int lim, input bit want, input bit ld);
        bit got;
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            tick(1);
            got = ld ? (load === 1'b1) : (fetch === 1'b1);
        end
        `CHK("event", want, got)
        if (want && !got) wrap_up();
    endtask : wait_on
    task automatic entry(input int s, input logic [3:0] l);
        cpu.processor_status_word = 16'h5800;
        `CHK("vector", 16'(16'h0100 + s * 4), cpu_out[23:8])
        `CHK("level", l, cpu_out.processor_status_word[15:12])
        tick(1);
    endtask : entry
    initial begin
        prio[1] = {4'h7, 2'h0};
        prio[2] = {4'h5, 2'h1};
        prio[3] = {4'h5, 2'h3};
        prio[4] = {4'h0, 2'h2};
        prio[5] = {4'h4, 2'h0};
        tick(20);
        rst_i = 1'b0;
        flag_set_i = 16'h001e;
        tick(1);
        flag_set_i = 16'h0000;
        wait_on(60, 1'b1, 1'b0);
        entry(3, 4'h5);
        `CHK("stack_psw", 16'h2800, pushes[0])
        `CHK("stack_cseg", 16'h0005, pushes[1])
        `CHK("stack_ret", 16'h1234, pushes[2])
        tick(3);
        `CHK("pending", 16'h0016, pend)
        wait_on(30, 1'b0, 1'b0);
        seg_off = 1'b1;
        mdb = 1'b1;
        pushes.delete();
        cpu.processor_status_word = 16'h4800;
        wait_on(60, 1'b1, 1'b0);
        entry(2, 4'h5);
        `CHK("flat", 2, pushes.size())
        `CHK("mdaddr", 16'h0abc, pushes[1])
        `CHK("mdflag", 1'b1, pushes[0][9])
        `CHK("mdpsw", 1'b1, cpu_out[33])
        mdb = 1'b0;
        for (int m = 0; m < 2; m++) begin
            seg_off = m[0];
            pops = 0;
            ret = 1'b1;
            tick(1);
            ret = 1'b0;
            wait_on(20, 1'b1, 1'b1);
            `CHK("restored", 32'h3800_2222, cpu_out[39:8])
            `CHK("cseg", (m == 0) ? 8'h07 : 8'h05, cpu_out[7:0])
            tick(2);
            `CHK("pops", 3 - m, pops)
        end
        cpu.processor_status_word = 16'h0000;
        flag_set_i[5] = 1'b1;
        tick(1);
        flag_set_i = 16'h0000;
        wait_on(20, 1'b0, 1'b0);
        `CHK("held", 1'b1, pend[5])
        cpu.processor_status_word = 16'h0800;
        wait_on(60, 1'b1, 1'b0);
        entry(5, 4'h4);
        lock = 1'b1;
        tick(1);
        lock = 1'b0;
        cpu.processor_status_word = 16'h0800;
        flag_set_i[5] = 1'b1;
        tick(1);
        flag_set_i = 16'h0000;
        tick(4);
        `CHK("locked", 1'b0, busy)
        wait_on(60, 1'b1, 1'b0);
        cpu.processor_status_word = 16'he800;
        prio[2] = {4'hf, 2'h0};
        flag_set_i[2] = 1'b1;
        tick(1);
        flag_set_i = 16'h0000;
        wait_on(60, 1'b1, 1'b0);
        entry(2, 4'hf);
        wrap_up();
    end
endmodule : irq_priority_save_tb_top
